// [verilog/ujtb_map.svh]
`ifndef UJTB_MAP_SVH
`define UJTB_MAP_SVH

// Register widths and instruction codes
`define UJTB_IR_WIDTH 8
`define UJTB_DR_WIDTH 16
`define UJTB_IR_USER_CODE 8'h22
`define UJTB_IR_BYPASS 8'hff
`define UJTB_IR_CAPTURE 8'h01
`define UJTB_PARAM_RESET 16'h0000

// Timing: system clock rate and link clock half period
`define UJTB_CLK_MHZ 125
`define UJTB_TCK_HALF_NS 80
`define UJTB_TCK_HALF_CYC ((`UJTB_TCK_HALF_NS * `UJTB_CLK_MHZ) / 1000)

// Host step counts per sequence phase
`define UJTB_RESET_TMS_CYCLES 5
`define UJTB_RESET_STEPS 6
`define UJTB_SEL_STEPS 2
`define UJTB_IR_PRE_STEPS 4
`define UJTB_DR_PRE_STEPS 3
`define UJTB_POST_STEPS 2
`define UJTB_FIFO_DEPTH 4

`endif

// [verilog/ujtb_pkg.sv]
package ujtb_pkg;

   // Test access port states, one-hot
   typedef enum logic [15:0] {
      TAP_RESET = 16'h0001,
      TAP_IDLE = 16'h0002,
      TAP_SEL_DR = 16'h0004,
      TAP_CAP_DR = 16'h0008,
      TAP_SHIFT_DR = 16'h0010,
      TAP_EXIT1_DR = 16'h0020,
      TAP_PAUSE_DR = 16'h0040,
      TAP_EXIT2_DR = 16'h0080,
      TAP_UPD_DR = 16'h0100,
      TAP_SEL_IR = 16'h0200,
      TAP_CAP_IR = 16'h0400,
      TAP_SHIFT_IR = 16'h0800,
      TAP_EXIT1_IR = 16'h1000,
      TAP_PAUSE_IR = 16'h2000,
      TAP_EXIT2_IR = 16'h4000,
      TAP_UPD_IR = 16'h8000
   } ujtb_tap_type;

   // Host sequencer phases, one-hot
   typedef enum logic [7:0] {
      H_IDLE = 8'h01,
      H_RESET = 8'h02,
      H_IR_PRE = 8'h04,
      H_IR_SHIFT = 8'h08,
      H_IR_POST = 8'h10,
      H_DR_PRE = 8'h20,
      H_DR_SHIFT = 8'h40,
      H_DR_POST = 8'h80
   } ujtb_host_type;

endpackage : ujtb_pkg

// [verilog/ujtb_link_if.sv]
`timescale 1ns/1ps

// Test access pins between host and device
interface ujtb_link_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic trst_n;

   modport host (output tck, output tms, output tdi, output trst_n, input tdo);
   modport device (input tck, input tms, input tdi, input trst_n, output tdo);
endinterface : ujtb_link_if

// [verilog/ujtb_fifo.sv]
`timescale 1ns/1ps

module ujtb_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;

   // Handshake decode
   wire push = in_valid_in && in_ready_out;
   wire pop = out_valid_out && out_ready_in;
   wire [PW-1:0] wr_ptr_inc = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'h1;
   wire [PW-1:0] rd_ptr_inc = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'h1;
   assign in_ready_out = (count_reg != CW'(DEPTH));
   assign out_valid_out = (count_reg != '0);
   assign out_data_out = mem[rd_ptr_reg];

   // Storage, no reset needed on data
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_in;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_inc;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_inc;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'h1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'h1;
         end
      end
   end
endmodule : ujtb_fifo

// [verilog/ujtb_device.sv]
`timescale 1ns/1ps
`include "ujtb_map.svh"

module ujtb_device #(
   parameter int IR_W = `UJTB_IR_WIDTH,
   parameter int DW = `UJTB_DR_WIDTH
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   ujtb_link_if.device link,
   output logic user_serial_data_out,
   output logic user_dr_shift_state_out,
   output logic user_dr_clock_out,
   output logic user_dr_update_state_out,
   output logic [DW-1:0] param_value_out,
   output logic param_updated_out,
   output logic [15:0] tap_state_out,
   output logic [IR_W-1:0] instr_out
);

   // Pin synchronisers
   logic tck_s1_reg;
   logic tck_s2_reg;
   logic tck_d_reg;
   logic tms_s1_reg;
   logic tms_s2_reg;
   logic tdi_s1_reg;
   logic tdi_s2_reg;
   logic trst_s1_reg;
   logic trst_s2_reg;

   // Controller state
   ujtb_pkg::ujtb_tap_type tap_reg;
   ujtb_pkg::ujtb_tap_type tap_next;
   logic [IR_W-1:0] ir_shift_reg;
   logic [IR_W-1:0] ir_reg;
   logic bypass_reg;
   logic tdo_reg;

   // User-side strobes and tuning registers
   logic serial_data_reg;
   logic dr_shift_reg;
   logic dr_clock_reg;
   logic dr_clock_d_reg;
   logic dr_update_reg;
   logic dr_update_d_reg;
   logic dr_capture_reg;
   logic [DW-1:0] temp_reg;
   logic [DW-1:0] param_reg;
   logic updated_reg;

   // Every pin passes two flops; tck_d only delays the clean copy
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tck_s1_reg <= 1'h0;
         tck_s2_reg <= 1'h0;
         tck_d_reg <= 1'h0;
         tms_s1_reg <= 1'h1;
         tms_s2_reg <= 1'h1;
         tdi_s1_reg <= 1'h0;
         tdi_s2_reg <= 1'h0;
         trst_s1_reg <= 1'h0;
         trst_s2_reg <= 1'h0;
      end else begin
         tck_s1_reg <= link.tck;
         tck_s2_reg <= tck_s1_reg;
         tck_d_reg <= tck_s2_reg;
         tms_s1_reg <= link.tms;
         tms_s2_reg <= tms_s1_reg;
         tdi_s1_reg <= link.tdi;
         tdi_s2_reg <= tdi_s1_reg;
         trst_s1_reg <= link.trst_n;
         trst_s2_reg <= trst_s1_reg;
      end
   end

   // Link clock edges found by the system clock
   wire tck_rise = tck_s2_reg && !tck_d_reg;
   wire tck_fall = !tck_s2_reg && tck_d_reg;
   wire tms = tms_s2_reg;

   // Next state from TMS; TMS high five times reaches reset from anywhere
   always_comb begin
      tap_next = ujtb_pkg::TAP_RESET;
      case (tap_reg)
         ujtb_pkg::TAP_RESET: begin
            tap_next = tms ? ujtb_pkg::TAP_RESET : ujtb_pkg::TAP_IDLE;
         end
         ujtb_pkg::TAP_IDLE: begin
            tap_next = tms ? ujtb_pkg::TAP_SEL_DR : ujtb_pkg::TAP_IDLE;
         end
         ujtb_pkg::TAP_SEL_DR: begin
            tap_next = tms ? ujtb_pkg::TAP_SEL_IR : ujtb_pkg::TAP_CAP_DR;
         end
         ujtb_pkg::TAP_CAP_DR: begin
            tap_next = tms ? ujtb_pkg::TAP_EXIT1_DR : ujtb_pkg::TAP_SHIFT_DR;
         end
         ujtb_pkg::TAP_SHIFT_DR: begin
            tap_next = tms ? ujtb_pkg::TAP_EXIT1_DR : ujtb_pkg::TAP_SHIFT_DR;
         end
         ujtb_pkg::TAP_EXIT1_DR: begin
            tap_next = tms ? ujtb_pkg::TAP_UPD_DR : ujtb_pkg::TAP_PAUSE_DR;
         end
         ujtb_pkg::TAP_PAUSE_DR: begin
            tap_next = tms ? ujtb_pkg::TAP_EXIT2_DR : ujtb_pkg::TAP_PAUSE_DR;
         end
         ujtb_pkg::TAP_EXIT2_DR: begin
            tap_next = tms ? ujtb_pkg::TAP_UPD_DR : ujtb_pkg::TAP_SHIFT_DR;
         end
         ujtb_pkg::TAP_UPD_DR: begin
            tap_next = tms ? ujtb_pkg::TAP_SEL_DR : ujtb_pkg::TAP_IDLE;
         end
         ujtb_pkg::TAP_SEL_IR: begin
            tap_next = tms ? ujtb_pkg::TAP_RESET : ujtb_pkg::TAP_CAP_IR;
         end
         ujtb_pkg::TAP_CAP_IR: begin
            tap_next = tms ? ujtb_pkg::TAP_EXIT1_IR : ujtb_pkg::TAP_SHIFT_IR;
         end
         ujtb_pkg::TAP_SHIFT_IR: begin
            tap_next = tms ? ujtb_pkg::TAP_EXIT1_IR : ujtb_pkg::TAP_SHIFT_IR;
         end
         ujtb_pkg::TAP_EXIT1_IR: begin
            tap_next = tms ? ujtb_pkg::TAP_UPD_IR : ujtb_pkg::TAP_PAUSE_IR;
         end
         ujtb_pkg::TAP_PAUSE_IR: begin
            tap_next = tms ? ujtb_pkg::TAP_EXIT2_IR : ujtb_pkg::TAP_PAUSE_IR;
         end
         ujtb_pkg::TAP_EXIT2_IR: begin
            tap_next = tms ? ujtb_pkg::TAP_UPD_IR : ujtb_pkg::TAP_SHIFT_IR;
         end
         ujtb_pkg::TAP_UPD_IR: begin
            tap_next = tms ? ujtb_pkg::TAP_SEL_DR : ujtb_pkg::TAP_IDLE;
         end
         default: begin
            tap_next = ujtb_pkg::TAP_RESET; // Illegal code recovers to reset
         end
      endcase
   end

   // Reset and TRST win over any TCK edge
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !trst_s2_reg) begin
         tap_reg <= ujtb_pkg::TAP_RESET;
      end else if (tck_rise) begin
         tap_reg <= tap_next;
      end
   end

   // State decode
   wire st_reset = (tap_reg == ujtb_pkg::TAP_RESET);
   wire st_cap_ir = (tap_reg == ujtb_pkg::TAP_CAP_IR);
   wire st_shift_ir = (tap_reg == ujtb_pkg::TAP_SHIFT_IR);
   wire st_upd_ir = (tap_reg == ujtb_pkg::TAP_UPD_IR);
   wire st_cap_dr = (tap_reg == ujtb_pkg::TAP_CAP_DR);
   wire st_shift_dr = (tap_reg == ujtb_pkg::TAP_SHIFT_DR);
   wire st_upd_dr = (tap_reg == ujtb_pkg::TAP_UPD_DR);
   wire user_sel = (ir_reg == IR_W'(`UJTB_IR_USER_CODE));

   // Instruction register: shift at rise, apply at fall in update
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ir_shift_reg <= '0;
         ir_reg <= IR_W'(`UJTB_IR_BYPASS);
      end else begin
         if (st_reset) begin
            ir_reg <= IR_W'(`UJTB_IR_BYPASS);
         end else if (tck_fall && st_upd_ir) begin
            ir_reg <= ir_shift_reg;
         end
         if (tck_rise && st_cap_ir) begin
            ir_shift_reg <= IR_W'(`UJTB_IR_CAPTURE);
         end else if (tck_rise && st_shift_ir) begin
            ir_shift_reg <= {tdi_s2_reg, ir_shift_reg[IR_W-1:1]};
         end
      end
   end

   // Bypass cell for any instruction but the user one
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         bypass_reg <= 1'h0;
      end else if (tck_rise && st_cap_dr) begin
         bypass_reg <= 1'h0;
      end else if (tck_rise && st_shift_dr) begin
         bypass_reg <= tdi_s2_reg;
      end
   end

   // TDO changes on falling TCK so the host samples a settled bit
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tdo_reg <= 1'h0;
      end else if (tck_fall && st_shift_ir) begin
         tdo_reg <= ir_shift_reg[0];
      end else if (tck_fall && st_shift_dr) begin
         tdo_reg <= user_sel ? temp_reg[0] : bypass_reg;
      end
   end

   // Strobes to user logic, all registered together to stay aligned
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         serial_data_reg <= 1'h0;
         dr_shift_reg <= 1'h0;
         dr_clock_reg <= 1'h0;
         dr_clock_d_reg <= 1'h0;
         dr_update_reg <= 1'h0;
         dr_update_d_reg <= 1'h0;
         dr_capture_reg <= 1'h0;
      end else begin
         serial_data_reg <= tdi_s2_reg;
         dr_shift_reg <= st_shift_dr && user_sel;
         dr_clock_reg <= tck_s2_reg;
         dr_clock_d_reg <= dr_clock_reg;
         dr_update_reg <= st_upd_dr && user_sel;
         dr_update_d_reg <= dr_update_reg;
         dr_capture_reg <= st_cap_dr && user_sel;
      end
   end

   // User fabric side: temporary register shifted by the bridge strobes
   wire udr_clock_rise = dr_clock_reg && !dr_clock_d_reg;
   wire udr_update_rise = dr_update_reg && !dr_update_d_reg;

   // Capture loads the live value so the host can read it back
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         temp_reg <= DW'(`UJTB_PARAM_RESET);
      end else if (udr_clock_rise && dr_capture_reg) begin
         temp_reg <= param_reg;
      end else if (udr_clock_rise && dr_shift_reg) begin
         temp_reg <= {serial_data_reg, temp_reg[DW-1:1]};
      end
   end

   // Permanent value moves only on entry to update, never mid-shift
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         param_reg <= DW'(`UJTB_PARAM_RESET);
         updated_reg <= 1'h0;
      end else begin
         updated_reg <= udr_update_rise;
         if (udr_update_rise) begin
            param_reg <= temp_reg;
         end
      end
   end

   // Outputs
   assign link.tdo = tdo_reg;
   assign user_serial_data_out = serial_data_reg;
   assign user_dr_shift_state_out = dr_shift_reg;
   assign user_dr_clock_out = dr_clock_reg;
   assign user_dr_update_state_out = dr_update_reg;
   assign param_value_out = param_reg;
   assign param_updated_out = updated_reg;
   assign tap_state_out = tap_reg;
   assign instr_out = ir_reg;

endmodule : ujtb_device

// [verilog/ujtb_host.sv]
`timescale 1ns/1ps
`include "ujtb_map.svh"

module ujtb_host #(
   parameter int IR_W = `UJTB_IR_WIDTH,
   parameter int DW = `UJTB_DR_WIDTH,
   parameter int DEPTH = `UJTB_FIFO_DEPTH
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   ujtb_link_if.host link,
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire logic [DW-1:0] cmd_data_in,
   output logic busy_out,
   output logic [DW-1:0] readback_out,
   output logic readback_valid_out
);
   localparam int HALF = `UJTB_TCK_HALF_CYC;
   localparam int HW = $clog2(HALF + 1);
   localparam int CNT_W = 8;
   localparam int SW = IR_W + DW;

   ujtb_pkg::ujtb_host_type st_reg;
   ujtb_pkg::ujtb_host_type st_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [SW-1:0] sh_reg;
   logic [SW-1:0] sh_next;
   logic [HW-1:0] half_reg;
   logic running_reg;
   logic tck_reg;
   logic tms_reg;
   logic tdi_reg;
   logic trst_n_reg;
   logic tdo_s1_reg;
   logic tdo_s2_reg;
   logic [DW-1:0] rb_reg;
   logic rb_valid_reg;
   logic fifo_valid;
   logic [DW-1:0] fifo_data;
   logic start;

   // Queue of values waiting to be tuned in; stalls the command port when full
   ujtb_fifo #(.W(DW), .DEPTH(DEPTH)) i_ujtb_fifo (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(cmd_valid_in),
      .in_ready_out(cmd_ready_out),
      .in_data_in(cmd_data_in),
      .out_valid_out(fifo_valid),
      .out_ready_in(start),
      .out_data_out(fifo_data)
   );

   // Step timing: one step is one full TCK period
   wire half_tick = running_reg && (half_reg == HW'(HALF - 1));
   wire step_done = half_tick && tck_reg;
   assign start = (st_reg == ujtb_pkg::H_IDLE) && fifo_valid;
   wire advance = step_done || start;
   wire [CNT_W-1:0] step_limit =
      (st_reg == ujtb_pkg::H_RESET) ? CNT_W'(`UJTB_RESET_STEPS) :
      (st_reg == ujtb_pkg::H_IR_PRE) ? CNT_W'(`UJTB_IR_PRE_STEPS) :
      (st_reg == ujtb_pkg::H_IR_SHIFT) ? CNT_W'(IR_W) :
      (st_reg == ujtb_pkg::H_DR_PRE) ? CNT_W'(`UJTB_DR_PRE_STEPS) :
      (st_reg == ujtb_pkg::H_DR_SHIFT) ? CNT_W'(DW) : CNT_W'(`UJTB_POST_STEPS);
   wire last = (cnt_reg == step_limit - 1'h1);
   wire in_shift = (st_reg == ujtb_pkg::H_IR_SHIFT) || (st_reg == ujtb_pkg::H_DR_SHIFT);

   // Phase sequence: instruction first, then data
   always_comb begin
      st_next = st_reg;
      cnt_next = last ? '0 : cnt_reg + 1'h1;
      sh_next = in_shift ? {1'h0, sh_reg[SW-1:1]} : sh_reg;
      case (st_reg)
         ujtb_pkg::H_IDLE: begin
            cnt_next = '0;
            if (fifo_valid) begin
               st_next = ujtb_pkg::H_IR_PRE;
               sh_next = {fifo_data, IR_W'(`UJTB_IR_USER_CODE)};
            end
         end
         ujtb_pkg::H_RESET: st_next = last ? ujtb_pkg::H_IDLE : st_reg;
         ujtb_pkg::H_IR_PRE: st_next = last ? ujtb_pkg::H_IR_SHIFT : st_reg;
         ujtb_pkg::H_IR_SHIFT: st_next = last ? ujtb_pkg::H_IR_POST : st_reg;
         ujtb_pkg::H_IR_POST: st_next = last ? ujtb_pkg::H_DR_PRE : st_reg;
         ujtb_pkg::H_DR_PRE: st_next = last ? ujtb_pkg::H_DR_SHIFT : st_reg;
         ujtb_pkg::H_DR_SHIFT: st_next = last ? ujtb_pkg::H_DR_POST : st_reg;
         ujtb_pkg::H_DR_POST: st_next = last ? ujtb_pkg::H_IDLE : st_reg;
         default: st_next = ujtb_pkg::H_RESET;
      endcase
   end

   // Pin levels for the coming step
   wire tms_next =
      (st_next == ujtb_pkg::H_IDLE) ? 1'h0 :
      (st_next == ujtb_pkg::H_RESET) ? (cnt_next < CNT_W'(`UJTB_RESET_TMS_CYCLES)) :
      (st_next == ujtb_pkg::H_IR_PRE) ? (cnt_next < CNT_W'(`UJTB_SEL_STEPS)) :
      (st_next == ujtb_pkg::H_IR_SHIFT) ? (cnt_next == CNT_W'(IR_W - 1)) :
      (st_next == ujtb_pkg::H_DR_SHIFT) ? (cnt_next == CNT_W'(DW - 1)) : (cnt_next == '0);
   wire next_shift = (st_next == ujtb_pkg::H_IR_SHIFT) || (st_next == ujtb_pkg::H_DR_SHIFT);
   wire tdi_next = next_shift && sh_next[0];

   // Sequencer registers; reset starts with the TMS-high reset walk
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st_reg <= ujtb_pkg::H_RESET;
         cnt_reg <= '0;
         sh_reg <= '0;
         running_reg <= 1'h1;
         tms_reg <= 1'h1;
         tdi_reg <= 1'h0;
      end else if (advance) begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         running_reg <= (st_next != ujtb_pkg::H_IDLE);
         tms_reg <= tms_next;
         tdi_reg <= tdi_next;
      end
   end

   // TCK divider, stands low while idle
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !running_reg || start) begin
         half_reg <= '0;
         tck_reg <= 1'h0;
      end else if (half_tick) begin
         half_reg <= '0;
         tck_reg <= !tck_reg;
      end else begin
         half_reg <= half_reg + 1'h1;
      end
   end

   // TRST held low only through system reset
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         trst_n_reg <= 1'h0;
      end else begin
         trst_n_reg <= 1'h1;
      end
   end

   // Old value returns on TDO during the data shift
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tdo_s1_reg <= 1'h0;
         tdo_s2_reg <= 1'h0;
         rb_reg <= '0;
         rb_valid_reg <= 1'h0;
      end else begin
         tdo_s1_reg <= link.tdo;
         tdo_s2_reg <= tdo_s1_reg;
         rb_valid_reg <= step_done && (st_reg == ujtb_pkg::H_DR_SHIFT) && last;
         if (half_tick && !tck_reg && (st_reg == ujtb_pkg::H_DR_SHIFT)) begin
            rb_reg <= {tdo_s2_reg, rb_reg[DW-1:1]};
         end
      end
   end

   assign link.tck = tck_reg;
   assign link.tms = tms_reg;
   assign link.tdi = tdi_reg;
   assign link.trst_n = trst_n_reg;
   assign busy_out = running_reg || fifo_valid;
   assign readback_out = rb_reg;
   assign readback_valid_out = rb_valid_reg;
endmodule : ujtb_host

// [verif/ujtb_assertions.sv]
`timescale 1ns/1ps

// Watches the link and the user strobes of the first device
module ujtb_checker (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic [15:0] tap_state_in,
   input wire logic shift_state_in,
   input wire logic update_state_in,
   input wire logic [15:0] param_value_in,
   input wire logic param_updated_in
);
   logic tck_prev_reg;
   logic [2:0] tms_run_reg;
   logic [2:0] tms_run_next;
   wire logic tck_rise;

   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   // Run length of TMS-high link edges, saturating so it never wraps
   assign tck_rise = tck_in & ~tck_prev_reg;
   assign tms_run_next = ~tms_in ? 3'h0 : (tms_run_reg == 3'h5) ? 3'h5 : tms_run_reg + 3'h1;

   // Edge finder and run counter
   always_ff @(posedge clk_in) begin
      tck_prev_reg <= tck_in;
      tms_run_reg <= sys_rst_in ? 3'h0 : tck_rise ? tms_run_next : tms_run_reg;
   end

   a_state_onehot: assert property ($onehot(tap_state_in))
      else $error("controller state not one-hot");
   a_state_at_rise: assert property ($changed(tap_state_in) |-> tck_in)
      else $error("state changed with link clock low");
   a_tms_at_fall: assert property ($changed(tms_in) |-> !tck_in)
      else $error("mode select changed with link clock high");
   a_five_high_reset: assert property (
      (tck_rise && tms_in && tms_run_reg == 3'h4) |-> ##[1:8] tap_state_in == ujtb_pkg::TAP_RESET)
      else $error("five high mode edges did not reset");
   a_param_hold_shift: assert property (shift_state_in |=> $stable(param_value_in))
      else $error("parameter moved while shifting");
   a_param_at_update: assert property ($changed(param_value_in) |-> update_state_in)
      else $error("parameter moved outside update state");
   a_update_pulse: assert property ($rose(update_state_in) |-> ##[1:3] param_updated_in)
      else $error("no update pulse after update state");
   a_pulse_single: assert property (param_updated_in |=> !param_updated_in)
      else $error("update pulse longer than one cycle");
   a_shift_state_match: assert property (
      $rose(shift_state_in) |-> ##[0:2] tap_state_in == ujtb_pkg::TAP_SHIFT_DR)
      else $error("shift state outside data shift");
   a_update_state_match: assert property (
      $rose(update_state_in) |-> ##[0:2] tap_state_in == ujtb_pkg::TAP_UPD_DR)
      else $error("update state outside data update");
endmodule : ujtb_checker

// [verif/test_user_jtag_tuning_bridge.sv]
`timescale 1ns/1ps

module test_user_jtag_tuning_bridge;
   logic clk_in;
   logic sys_rst_in;
   logic cmd_valid_in;
   logic [15:0] cmd_data_in;
   logic cmd_ready_out;
   logic busy_out;
   logic [15:0] readback_out;
   logic readback_valid_out;
   logic [15:0] param_a;
   logic [15:0] state_a;
   logic [15:0] state_b;
   logic [7:0] instr_a;
   logic shift_a;
   logic upd_a;
   logic updp_a;
   logic shift_b;
   logic ok;
   int n;
   int miscompares;
   int compares;
   int cycles;
   logic [15:0] vals [8] = '{16'h1234, 16'h0f0f, 16'hffff, 16'h8001, 16'h5a5a, 16'h0000, 16'h7e7e, 16'hc3c3};

   ujtb_link_if link_a ();
   ujtb_link_if link_b ();

   ujtb_host i_ujtb_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link_a), .cmd_valid_in(cmd_valid_in),
      .cmd_ready_out(cmd_ready_out), .cmd_data_in(cmd_data_in), .busy_out(busy_out), .readback_out(readback_out),
      .readback_valid_out(readback_valid_out));
   ujtb_device i_ujtb_device (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link_a), .user_serial_data_out(),
      .user_dr_shift_state_out(shift_a), .user_dr_clock_out(), .user_dr_update_state_out(upd_a),
      .param_value_out(param_a), .param_updated_out(updp_a), .tap_state_out(state_a), .instr_out(instr_a));
   // Spare device on a link driven by the bench itself
   ujtb_device i_ujtb_device_b (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link_b), .user_serial_data_out(),
      .user_dr_shift_state_out(shift_b), .user_dr_clock_out(), .user_dr_update_state_out(),
      .param_value_out(), .param_updated_out(), .tap_state_out(state_b), .instr_out());
   ujtb_checker i_ujtb_checker (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .tck_in(link_a.tck), .tms_in(link_a.tms),
      .tap_state_in(state_a), .shift_state_in(shift_a), .update_state_in(upd_a),
      .param_value_in(param_a), .param_updated_in(updp_a));

   // Clock
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task report_and_stop;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   // Whole queue plus spare link takes about 4000 cycles
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // One link clock period on the spare link, mode select set while low
   task automatic step_b(input logic t);
      #1 link_b.tms = t;
      repeat (10) @(posedge clk_in);
      #1 link_b.tck = 1'b1;
      repeat (10) @(posedge clk_in);
      #1 link_b.tck = 1'b0;
   endtask : step_b

   task automatic walk_b(input logic [7:0] bits, input int cnt);
      for (int i = 0; i < cnt; i++) step_b(bits[i]);
      repeat (4) @(posedge clk_in);
   endtask : walk_b

   // Valid stays up between calls; caller drops it
   task automatic push(input logic [15:0] d, output logic taken);
      #1 cmd_valid_in = 1'b1;
      cmd_data_in = d;
      // Ready only moves at the rising edge, so mid-cycle shows what that edge takes
      @(negedge clk_in);
      taken = cmd_ready_out;
      @(posedge clk_in);
   endtask : push

   task automatic wait_update(input logic [15:0] exp_param, input logic [15:0] exp_rb);
      int w;
      w = 0;
      while (readback_valid_out !== 1'b1 && w < 3000) begin
         @(posedge clk_in);
         #1;
         w++;
      end
      check("readback", exp_rb, readback_out);
      // Readback ends the shift; the permanent value moves later, at update
      while (updp_a !== 1'b1 && w < 3200) begin
         @(posedge clk_in);
         #1;
         w++;
      end
      check("param", exp_param, param_a);
      @(posedge clk_in);
   endtask : wait_update

   initial begin
      sys_rst_in = 1'b1;
      cmd_valid_in = 1'b0;
      cmd_data_in = 16'h0000;
      link_b.tck = 1'b0;
      link_b.tms = 1'b1;
      link_b.tdi = 1'b0;
      link_b.trst_n = 1'b0;
      cycles = 0;
      miscompares = 0;
      compares = 0;
      repeat (8) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
      link_b.trst_n = 1'b1;
      check("state", 16'h0001, state_a);
      check("instr", 16'h00ff, {8'h00, instr_a});
      check("param", 16'h0000, param_a);
      $display("test reset done");
      @(posedge clk_in);
      push(16'ha5c3, ok);
      #1 cmd_valid_in = 1'b0;
      wait_update(16'ha5c3, 16'h0000);
      check("instr", 16'h0022, {8'h00, instr_a});
      $display("test single update done");
      // Back-to-back pushes until the queue refuses
      n = 0;
      ok = 1'b1;
      while (ok && n < 8) begin
         push(vals[n], ok);
         if (ok) n++;
      end
      #1 cmd_valid_in = 1'b0;
      check("refused", 16'h0000, {15'h0000, ok});
      check("accepted", 16'h0001, {15'h0000, n >= 4 && n <= 5});
      for (int i = 0; i < n; i++) wait_update(vals[i], i == 0 ? 16'ha5c3 : vals[i - 1]);
      // The end of the first closing link step and the whole second step still follow the last update
      repeat (40) @(posedge clk_in);
      check("busy", 16'h0000, {15'h0000, busy_out});
      $display("test queue done");
      walk_b(8'h02, 4);
      check("state b", 16'h0010, state_b);
      check("bypass shift", 16'h0000, {15'h0000, shift_b});
      #1 link_b.trst_n = 1'b0;
      repeat (6) @(posedge clk_in);
      check("state b", 16'h0001, state_b);
      #1 link_b.trst_n = 1'b1;
      walk_b(8'h06, 5);
      check("state b", 16'h0800, state_b);
      walk_b(8'h0f, 4);
      check("state b", 16'h0200, state_b);
      walk_b(8'h01, 1);
      check("state b", 16'h0001, state_b);
      $display("test spare link done");
      report_and_stop();
   end
endmodule : test_user_jtag_tuning_bridge
